// ===== bench/scalar_issue_model.sv
// Issue-side partner: scalar register file feeding operands
`timescale 1ns/1ps
module scalar_issue_model (
   input wire logic clk,
   input wire logic rst,
   input scalar_unit_pkg::issue_req_s req,
   input wire logic [23:0] a_count,
   input scalar_unit_pkg::result_s logic_wr,
   input scalar_unit_pkg::result_s shift_wr,
   output scalar_unit_pkg::operand_s operands
);
   logic [63:0] s_reg[8];
   logic [63:0] junk;
   // Write back at the edge ending the result cycle
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         for (int n = 0; n < 8; n++) s_reg[n] <= {8{8'h11 * 8'(n) + 8'h3c}};
         junk <= 64'h5a5a_c3c3_0ff0_9669;
      end else begin
         junk <= ~junk;
         if (logic_wr.valid) s_reg[logic_wr.dest] <= logic_wr.data;
         if (shift_wr.valid) s_reg[shift_wr.dest] <= shift_wr.data;
      end
   end
   // Without a request the operands toggle, so stale values never look right
   assign operands = req.valid ? {s_reg[req.i], s_reg[req.j], s_reg[req.k], a_count}
      : {junk, ~junk, junk, junk[23:0]};
endmodule

// ===== bench/scalar_logic_and_shift_units_tb_top.sv
// Random self-checking bench with a cycle model of issue and results
`timescale 1ns/1ps
module scalar_logic_and_shift_units_tb_top;
   logic clk, rst, scalar_add_issued, issue_ready, issue_taken, last_dbl, last_add, er;
   logic [7:0] s_busy_ext, a_busy_ext, reserved, resv;
   logic [23:0] a_count;
   logic [63:0] res;
   logic [63:0] s_m[8];
   scalar_unit_pkg::issue_req_s req;
   scalar_unit_pkg::operand_s operands;
   scalar_unit_pkg::result_s logic_wr, shift_wr, exp_l;
   scalar_unit_pkg::result_s sh[3];
   int fails = 0;
   int n_tests = 0;
   int seed, cyc = 0;

   scalar_logic_and_shift_units scalar_logic_and_shift_units_i (.clk(clk), .rst(rst),
      .req(req), .operands(operands), .s_busy_ext(s_busy_ext), .a_busy_ext(a_busy_ext),
      .scalar_add_issued(scalar_add_issued), .issue_ready(issue_ready),
      .issue_taken(issue_taken), .logic_wr(logic_wr), .shift_wr(shift_wr),
      .reserved(reserved));
   scalar_issue_model scalar_issue_model_i (.clk(clk), .rst(rst), .req(req),
      .a_count(a_count), .logic_wr(logic_wr), .shift_wr(shift_wr), .operands(operands));

   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   // Hang guard; the run needs about 4000 cycles
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 6000) begin
         fails = fails + 1;
         test_done();
      end
   end

   task automatic check(input logic [67:0] seen, input logic [67:0] want);
      n_tests++;
      if (seen !== want) begin
         fails++;
         $display("unexpected at %0t: saw %h want %h", $time, seen, want);
      end
   endtask

   task automatic test_done();
      if (fails == 0 && n_tests > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask

   // Expected result from the mirror; the 128-bit window also gives rotation
   function automatic logic [63:0] model(input logic [6:0] op, input logic [2:0] i, j, k);
      logic [63:0] si, sj, sk;
      logic [127:0] w;
      logic [23:0] n;
      si = s_m[i];
      sj = (j == 3'h0) ? 64'h0 : s_m[j];
      sk = (k == 3'h0) ? 64'h8000_0000_0000_0000 : s_m[k];
      n = (k == 3'h0) ? 24'h1 : a_count;
      w = (op == 7'h2e) ? {si, sj} << n : {sj, si} >> n;
      case (op)
         7'h24: return sj & sk;
         7'h25: return sj & ~sk;
         7'h26: return sj ^ sk;
         7'h27: return ~(sj ^ sk);
         7'h28: return (sj & sk) | (si & ~sk);
         7'h29: return sj | sk;
         7'h2a, 7'h2c: return si << {j, k};
         7'h2b, 7'h2d: return ({j, k} == 6'h0) ? 64'h0 : si >> (7'h40 - {j, k});
         default: return (n > 24'h7f) ? 64'h0 : (op == 7'h2e ? w[127:64] : w[63:0]);
      endcase
   endfunction

   // Expected issue readiness from the modelled reservations
   function automatic logic ready_model();
      logic [7:0] r;
      r = resv | s_busy_ext;
      if (req.opcode < 7'h24 || req.opcode > 7'h2f) return 1'b0;
      if (req.opcode < 7'h2a) return !r[req.i] && !(req.j && r[req.j]) && !(req.k && r[req.k]);
      if (req.opcode < 7'h2e)
         return !r[req.i] && !(req.opcode < 7'h2c && r[0]) && !last_dbl && !last_add;
      return !r[req.i] && !(req.j && r[req.j]) && !(req.k && a_busy_ext[req.k]);
   endfunction

   initial begin
      seed = 66;
      rst = 1'b1;
      req = '0;
      {s_busy_ext, a_busy_ext, scalar_add_issued, a_count} = '0;
      {exp_l, resv, last_dbl, last_add} = '0;
      sh = '{default: '0};
      for (int n = 0; n < 8; n++) s_m[n] = {8{8'h11 * 8'(n) + 8'h3c}};
      repeat (2) @(negedge clk);
      rst = 1'b0;
      for (int t = 0; t < 4000; t++) begin
         check(logic_wr, exp_l);
         check(shift_wr, sh[0]);
         check(68'(reserved), 68'(resv));
         req.valid = ($random(seed) & 3) != 0;
         req.opcode = 7'h24 + 7'(($random(seed) & 255) % 13);
         {req.i, req.j, req.k} = 9'($random(seed));
         if (($random(seed) & 3) == 0) req.j = req.i;
         a_count = 24'($random(seed) & 3) + 24'h3f * 24'($random(seed) & 3);
         if (t % 16 == 0) a_count = 24'($random(seed));
         s_busy_ext = 8'($random(seed)) & 8'($random(seed)) & 8'($random(seed));
         a_busy_ext = 8'($random(seed)) & 8'($random(seed)) & 8'($random(seed));
         scalar_add_issued = ($random(seed) & 7) == 0;
         #1;
         er = ready_model();
         check(68'(issue_ready), 68'(er));
         check(68'(issue_taken), 68'(er & req.valid));
         @(posedge clk);
         res = model(req.opcode, req.i, req.j, req.k);
         if (exp_l.valid) s_m[exp_l.dest] = exp_l.data;
         if (sh[0].valid) s_m[sh[0].dest] = sh[0].data;
         exp_l = '0;
         sh[0] = sh[1];
         sh[1] = sh[2];
         sh[2] = '0;
         if (er && req.valid) begin
            if (req.opcode < 7'h2a) exp_l = {1'b1, req.i, res};
            else if (req.opcode < 7'h2e)
               sh[1] = {1'b1, (req.opcode < 7'h2c) ? 3'h0 : req.i, res};
            else sh[2] = {1'b1, req.i, res};
         end
         last_dbl = er && req.valid && req.opcode > 7'h2d;
         last_add = scalar_add_issued;
         resv = 8'h00;
         if (exp_l.valid) resv[exp_l.dest] = 1'b1;
         for (int s = 0; s < 3; s++) if (sh[s].valid) resv[sh[s].dest] = 1'b1;
         @(negedge clk);
      end
      test_done();
   end
endmodule

bind scalar_logic_and_shift_units scalar_units_sva scalar_units_sva_i (.clk(clk), .rst(rst),
   .req(req), .operands(operands), .s_busy_ext(s_busy_ext), .a_busy_ext(a_busy_ext),
   .scalar_add_issued(scalar_add_issued), .issue_ready(issue_ready),
   .issue_taken(issue_taken), .logic_wr(logic_wr), .shift_wr(shift_wr),
   .reserved(reserved));

// ===== bench/scalar_units_sva.sv
// Port-level assertions for the scalar logic and shift units
`timescale 1ns/1ps
module scalar_units_sva (
   input wire logic clk,
   input wire logic rst,
   input scalar_unit_pkg::issue_req_s req,
   input scalar_unit_pkg::operand_s operands,
   input wire logic [7:0] s_busy_ext,
   input wire logic [7:0] a_busy_ext,
   input wire logic scalar_add_issued,
   input wire logic issue_ready,
   input wire logic issue_taken,
   input scalar_unit_pkg::result_s logic_wr,
   input scalar_unit_pkg::result_s shift_wr,
   input wire logic [7:0] reserved
);
   logic lg, im, db, dbl_taken;
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);
   // Opcode classes decoded here, not borrowed from the design
   assign lg = req.opcode >= 7'h24 && req.opcode <= 7'h29;
   assign im = req.opcode >= 7'h2a && req.opcode <= 7'h2d;
   assign db = req.opcode >= 7'h2e && req.opcode <= 7'h2f;
   assign dbl_taken = issue_taken && db;

   chk_taken_means: assert property (issue_taken == (req.valid && issue_ready))
      else $error("taken differs from valid and ready");
   chk_logic_one_cycle: assert property (issue_taken && lg |=>
      logic_wr.valid && logic_wr.dest == $past(req.i)) else $error("logical result late");
   chk_or_value: assert property (issue_taken && req.opcode == 7'h29 && req.j && req.k |=>
      logic_wr.data == ($past(operands.first_scalar_src) | $past(operands.second_scalar_src)))
      else $error("or result wrong");
   chk_xnor_value: assert property (issue_taken && req.opcode == 7'h27 && req.j && req.k |=>
      logic_wr.data == ($past(operands.first_scalar_src) ~^ $past(operands.second_scalar_src)))
      else $error("equivalence result wrong");
   chk_imm_two_cycles: assert property (issue_taken && im |-> ##2 shift_wr.valid &&
      shift_wr.dest == ($past(req.opcode, 2) < 7'h2c ? 3'h0 : $past(req.i, 2)))
      else $error("immediate shift result late");
   chk_dbl_three_cycles: assert property (dbl_taken |-> ##3
      shift_wr.valid && shift_wr.dest == $past(req.i, 3)) else $error("double shift late");
   chk_imm_after_dbl: assert property (issue_ready && im |->
      !$past(dbl_taken) && !$past(scalar_add_issued)) else $error("immediate shift not held");
   chk_logic_hold: assert property (issue_ready && lg |->
      !(reserved[req.i] || s_busy_ext[req.i])) else $error("logical issued on reserved");
   chk_dbl_areg_hold: assert property (issue_ready && db && req.k != 3'h0 |->
      !a_busy_ext[req.k]) else $error("double shift issued on busy count");
   chk_resv_release: assert property (logic_wr.valid |-> reserved[logic_wr.dest] ##1
      !reserved[$past(logic_wr.dest)]) else $error("reservation not released at write");
   chk_shr_empty: assert property (issue_taken && req.opcode == 7'h2d &&
      {req.j, req.k} == 6'h0 |-> ##2 shift_wr.data == 64'h0) else $error("full right shift");

   cover property (dbl_taken);
   cover property (req.valid && im && !issue_ready);
   cover property (logic_wr.valid && shift_wr.valid);
endmodule

// ===== verilog/scalar_logic_and_shift_units.sv
// Scalar logical and shift units with issue-hold interlocks and result pipelines
//
// Operation
// RL1: XOR special fields: zero, pass, sign-flipped pass
// RL2: Equivalence writes one where source bits match
// RL3: Equivalence special fields: ones, complement, near-complement
// RL4: Merge takes first source where mask set
// RL5: Merge special fields clear or copy sign
// RL6: OR sets bit where either source set
// RL7: OR special fields: pass, sign forced, sign only
// RL8: Logical holds on reserved registers; one period result
// RL9: Immediate shifts are end-off with zero fill
// RL10: Left immediate shift by field, 0 to 63
// RL11: Right immediate shift by 64 minus field
// RL12: Immediate shift held after double, add, subtract
// RL13: Immediate shift holds on destination; two periods
// RL14: Double shift over 128 bits, 24-bit count
// RL15: Zero count field shifts one; zero word
// RL16: Equal nonzero fields rotate up to 64
// RL17: Equal fields beyond 64 act as single shift
// RL18: Double left keeps upper word; clears past 127
// RL19: Double right keeps lower word; clears past 127
// RL20: Double shift writes only destination register
// RL21: AND gives product, difference gives XOR
// RL22: Double shift holds on reservations; three periods
// RL23: Fully pipelined; reservation drops at write
`timescale 1ns/1ps
module scalar_logic_and_shift_units (
   input wire logic clk,
   input wire logic rst,
   input scalar_unit_pkg::issue_req_s req,
   input scalar_unit_pkg::operand_s operands,
   input wire logic [7:0] s_busy_ext,
   input wire logic [7:0] a_busy_ext,
   input wire logic scalar_add_issued,
   output logic issue_ready,
   output logic issue_taken,
   output scalar_unit_pkg::result_s logic_wr,
   output scalar_unit_pkg::result_s shift_wr,
   output logic [7:0] reserved
);

   localparam int DEPTH = scalar_unit_pkg::DBL_SHIFT_LAT;
   localparam int IMM_ENTRY = scalar_unit_pkg::DBL_SHIFT_LAT -
      scalar_unit_pkg::IMM_SHIFT_LAT;

   // Whole state of the block
   typedef struct packed {
      logic [7:0] resv;
      logic prev_dbl;
      logic prev_add;
      scalar_unit_pkg::result_s logic_out;
      scalar_unit_pkg::result_s [DEPTH-1:0] pipe;
   } state_s;

   state_s state_reg;
   state_s state_next;
   scalar_unit_pkg::op_class_e cls;
   logic [7:0] busy;
   logic hold;
   logic [2:0] dest;
   logic [63:0] logic_data;
   logic [63:0] shift_data;

   scalar_logic_fn u_logic (
      .opcode(req.opcode),
      .j(req.j),
      .k(req.k),
      .si_val(operands.si_val),
      .first_scalar_src(operands.first_scalar_src),
      .second_scalar_src(operands.second_scalar_src),
      .data(logic_data)
   );

   scalar_shift_fn #(
      .COUNT_W(scalar_unit_pkg::AREG_W)
   ) u_shift (
      .opcode(req.opcode),
      .i(req.i),
      .j(req.j),
      .k(req.k),
      .si_val(operands.si_val),
      .first_scalar_src(operands.first_scalar_src),
      .shift_count_areg(operands.shift_count_areg),
      .data(shift_data)
   );

   // Reserved: held by this block or by any other unit
   function automatic logic in_use(input logic [7:0] vec, input logic [2:0] r, input logic skip0);
      return vec[r] && !(skip0 && r == scalar_unit_pkg::ZERO_REG);
   endfunction

   // Issue-hold decision per opcode class
   always_comb begin
      cls = scalar_unit_pkg::classify(req.opcode);
      busy = state_reg.resv | s_busy_ext;
      dest = req.i;
      case (cls)
         scalar_unit_pkg::CLS_LOGIC: begin
            hold = in_use(busy, req.i, 1'b0) || in_use(busy, req.j, 1'b1) ||
               in_use(busy, req.k, 1'b1); // RL8
         end
         scalar_unit_pkg::CLS_IMM: begin
            // Shared result path with double shift and adder is busy next period
            hold = state_reg.prev_dbl || state_reg.prev_add || in_use(busy, req.i, 1'b0); // RL12 RL13
            if (req.opcode == scalar_unit_pkg::OP_SHL_TO_ZERO ||
               req.opcode == scalar_unit_pkg::OP_SHR_TO_ZERO) begin
               dest = scalar_unit_pkg::ZERO_REG; // RL10 RL11
               hold = hold || busy[scalar_unit_pkg::ZERO_REG]; // RL13
            end
         end
         scalar_unit_pkg::CLS_DBL: begin
            hold = in_use(busy, req.i, 1'b0) || in_use(busy, req.j, 1'b1) ||
               in_use(a_busy_ext, req.k, 1'b1); // RL22
         end
         default: hold = 1'b1;
      endcase
      issue_ready = (cls != scalar_unit_pkg::CLS_NONE) && !hold;
      issue_taken = req.valid && issue_ready; // RL23
   end

   // Next state: pipelines advance every period, reservations follow writes
   always_comb begin
      state_next = state_reg;
      state_next.prev_add = scalar_add_issued; // RL12
      state_next.prev_dbl = issue_taken && cls == scalar_unit_pkg::CLS_DBL; // RL12
      // Release exactly at the write edge; a same-edge issue cannot target it
      if (state_reg.logic_out.valid) begin
         state_next.resv[state_reg.logic_out.dest] = 1'b0; // RL23
      end
      if (state_reg.pipe[DEPTH-1].valid) begin
         state_next.resv[state_reg.pipe[DEPTH-1].dest] = 1'b0; // RL23
      end
      state_next.logic_out = '0;
      for (int n = DEPTH - 1; n > 0; n--) begin
         state_next.pipe[n] = state_reg.pipe[n-1];
      end
      state_next.pipe[0] = '0;
      if (issue_taken) begin
         state_next.resv[dest] = 1'b1; // RL20
         case (cls)
            scalar_unit_pkg::CLS_LOGIC: begin
               state_next.logic_out = '{valid: 1'b1, dest: dest, data: logic_data}; // RL8
            end
            scalar_unit_pkg::CLS_IMM: begin
               state_next.pipe[IMM_ENTRY] = '{valid: 1'b1, dest: dest, data: shift_data}; // RL13
            end
            scalar_unit_pkg::CLS_DBL: begin
               state_next.pipe[0] = '{valid: 1'b1, dest: dest, data: shift_data}; // RL22
            end
            default: state_next.resv[dest] = state_reg.resv[dest];
         endcase
      end
   end

   // State register
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         state_reg <= '0;
         state_reg.resv <= scalar_unit_pkg::RESV_RESET;
      end else begin
         state_reg <= state_next;
      end
   end

   // Results come straight from flip-flops
   assign logic_wr = state_reg.logic_out;
   assign shift_wr = state_reg.pipe[DEPTH-1];
   assign reserved = state_reg.resv;

endmodule

// ===== verilog/scalar_logic_fn.sv
// Combinational scalar logical function: AND, AND-NOT, XOR, XNOR, merge, OR
`timescale 1ns/1ps
module scalar_logic_fn (
   input wire logic [6:0] opcode,
   input wire logic [2:0] j,
   input wire logic [2:0] k,
   input wire logic [63:0] si_val,
   input wire logic [63:0] first_scalar_src,
   input wire logic [63:0] second_scalar_src,
   output logic [63:0] data
);

   logic [63:0] a;
   logic [63:0] b;

   // Designator substitution gives every special case from the plain equations
   always_comb begin
      a = (j == scalar_unit_pkg::ZERO_REG) ? scalar_unit_pkg::ZERO_WORD : first_scalar_src;
      if (k == scalar_unit_pkg::ZERO_REG) begin
         b = scalar_unit_pkg::SIGN_MASK;
      end else if (k == j) begin
         b = a; // Equal fields read one register, so force identical words
      end else begin
         b = second_scalar_src;
      end
   end

   // Function select
   always_comb begin
      case (opcode)
         scalar_unit_pkg::OP_AND: data = a & b; // RL21
         scalar_unit_pkg::OP_ANDN: data = a & ~b;
         scalar_unit_pkg::OP_XOR: data = a ^ b; // RL1 RL21
         scalar_unit_pkg::OP_XNOR: data = ~(a ^ b); // RL2 RL3
         scalar_unit_pkg::OP_MERGE: data = (a & b) | (si_val & ~b); // RL4 RL5
         scalar_unit_pkg::OP_OR: data = a | b; // RL6 RL7
         default: data = scalar_unit_pkg::ZERO_WORD;
      endcase
   end

endmodule

// ===== verilog/scalar_shift_fn.sv
// Combinational scalar shifter: immediate single-word and count-register double-word shifts
`timescale 1ns/1ps
module scalar_shift_fn #(
   parameter int COUNT_W = 24
) (
   input wire logic [6:0] opcode,
   input wire logic [2:0] i,
   input wire logic [2:0] j,
   input wire logic [2:0] k,
   input wire logic [63:0] si_val,
   input wire logic [63:0] first_scalar_src,
   input wire logic [COUNT_W-1:0] shift_count_areg,
   output logic [63:0] data
);

   // The 128-bit window needs at least seven count bits
   if (COUNT_W < 7 || COUNT_W > 32) begin : g_count_check
      $error("scalar_shift_fn: COUNT_W must lie in 7..32");
   end

   logic [5:0] immediate_shift_field;
   logic [7:0] right_amt;
   logic [COUNT_W-1:0] cnt;
   logic [63:0] lo_word;
   logic [127:0] joined;
   logic [127:0] moved;
   logic too_far;

   always_comb begin
      immediate_shift_field = {j, k};
      right_amt = scalar_unit_pkg::IMM_RIGHT_BASE - {2'b00, immediate_shift_field}; // RL11
      // Zero count field means one place
      cnt = (k == scalar_unit_pkg::ZERO_REG) ?
         COUNT_W'(scalar_unit_pkg::DBL_ZERO_COUNT) : shift_count_areg; // RL14 RL15
      // Zero second field feeds a zero word; equal fields feed the same word
      if (j == scalar_unit_pkg::ZERO_REG) begin
         lo_word = scalar_unit_pkg::ZERO_WORD; // RL15
      end else if (j == i) begin
         lo_word = si_val; // RL16 RL17
      end else begin
         lo_word = first_scalar_src;
      end
      too_far = (cnt > COUNT_W'(scalar_unit_pkg::DBL_COUNT_MAX)); // RL18 RL19
      joined = (opcode == scalar_unit_pkg::OP_DSHL) ? {si_val, lo_word} : {lo_word, si_val};
      // With equal words the 128-bit shift is a rotate up to 64, end-off beyond
      moved = (opcode == scalar_unit_pkg::OP_DSHL) ?
         joined << cnt[6:0] : joined >> cnt[6:0]; // RL16 RL17
      case (opcode)
         scalar_unit_pkg::OP_SHL_TO_ZERO,
         scalar_unit_pkg::OP_SHL_SELF: data = si_val << immediate_shift_field; // RL9 RL10
         scalar_unit_pkg::OP_SHR_TO_ZERO,
         scalar_unit_pkg::OP_SHR_SELF: data = si_val >> right_amt; // RL9 RL11
         scalar_unit_pkg::OP_DSHL: data = too_far ? scalar_unit_pkg::ZERO_WORD : moved[127:64]; // RL18
         scalar_unit_pkg::OP_DSHR: data = too_far ? scalar_unit_pkg::ZERO_WORD : moved[63:0]; // RL19
         default: data = scalar_unit_pkg::ZERO_WORD;
      endcase
   end

endmodule

// ===== verilog/scalar_unit_pkg.sv
// Shared constants, opcodes and carrier types for the scalar logic and shift units
package scalar_unit_pkg;

   // Data path widths
   localparam int WORD_W = 64;
   localparam int REG_N = 8;
   localparam int AREG_W = 24;
   localparam int IMM_W = 6;
   localparam int PERIOD_NS = 10;

   // Sign bit stands in for a zero second designator
   localparam logic [63:0] SIGN_MASK = 64'h8000_0000_0000_0000;
   localparam logic [63:0] ALL_ONES = 64'hffff_ffff_ffff_ffff;
   localparam logic [63:0] ZERO_WORD = 64'h0000_0000_0000_0000;

   // Opcodes, the two-digit octal field held in seven bits
   localparam logic [6:0] OP_AND = 7'h24;
   localparam logic [6:0] OP_ANDN = 7'h25;
   localparam logic [6:0] OP_XOR = 7'h26;
   localparam logic [6:0] OP_XNOR = 7'h27;
   localparam logic [6:0] OP_MERGE = 7'h28;
   localparam logic [6:0] OP_OR = 7'h29;
   localparam logic [6:0] OP_SHL_TO_ZERO = 7'h2a;
   localparam logic [6:0] OP_SHR_TO_ZERO = 7'h2b;
   localparam logic [6:0] OP_SHL_SELF = 7'h2c;
   localparam logic [6:0] OP_SHR_SELF = 7'h2d;
   localparam logic [6:0] OP_DSHL = 7'h2e;
   localparam logic [6:0] OP_DSHR = 7'h2f;

   // Result latencies in clock periods after issue
   localparam int LOGIC_LAT = 1;
   localparam int IMM_SHIFT_LAT = 2;
   localparam int DBL_SHIFT_LAT = 3;

   // Reset values and fixed counts
   localparam logic [7:0] RESV_RESET = 8'h00;
   localparam logic [2:0] ZERO_REG = 3'h0;
   localparam logic [7:0] IMM_RIGHT_BASE = 8'h40;
   localparam logic [7:0] DBL_COUNT_MAX = 8'h7f;
   localparam logic [7:0] DBL_ZERO_COUNT = 8'h01;

   typedef enum logic [1:0] {
      CLS_NONE,
      CLS_LOGIC,
      CLS_IMM,
      CLS_DBL
   } op_class_e;

   typedef struct packed {
      logic valid;
      logic [6:0] opcode;
      logic [2:0] i;
      logic [2:0] j;
      logic [2:0] k;
   } issue_req_s;

   typedef struct packed {
      logic [63:0] si_val;
      logic [63:0] first_scalar_src;
      logic [63:0] second_scalar_src;
      logic [23:0] shift_count_areg;
   } operand_s;

   typedef struct packed {
      logic valid;
      logic [2:0] dest;
      logic [63:0] data;
   } result_s;

   // Sorts an opcode into the unit that serves it
   function automatic op_class_e classify(input logic [6:0] op);
      op_class_e c;
      c = CLS_NONE;
      if (op >= OP_AND && op <= OP_OR) begin
         c = CLS_LOGIC;
      end else if (op >= OP_SHL_TO_ZERO && op <= OP_SHR_SELF) begin
         c = CLS_IMM;
      end else if (op == OP_DSHL || op == OP_DSHR) begin
         c = CLS_DBL;
      end
      return c;
   endfunction

endpackage
